// ### core/etsr_defs.vh
`ifndef ETSR_DEFS_VH
`define ETSR_DEFS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define ETSR_ADDR_W 12
`define ETSR_OFS_UNIT_INDEX 12'h500
`define ETSR_OFS_S5_PHASE 12'h58C
`define ETSR_OFS_S6_NANOS 12'h590
`define ETSR_OFS_S6_SECS 12'h594
`define ETSR_OFS_S6_PHASE 12'h598
`define ETSR_OFS_S7_NANOS 12'h59C
`define ETSR_OFS_S7_SECS 12'h5A0

// ************************************************************
// Field positions and widths
// ************************************************************
`define ETSR_UNIT_PTR_BIT 8
`define ETSR_POL_BIT 30
`define ETSR_NANOS_W 30
`define ETSR_SECS_W 32
`define ETSR_PHASE_W 3

// ************************************************************
// Sub-cycle phase codes, one per 8ns slot of the 40ns cycle
// ************************************************************
`define ETSR_PH_0NS 3'h0
`define ETSR_PH_8NS 3'h1
`define ETSR_PH_16NS 3'h2
`define ETSR_PH_24NS 3'h3
`define ETSR_PH_32NS 3'h4

// ************************************************************
// Capture slot select and reset values
// ************************************************************
`define ETSR_SLOT_5TH 2'h1
`define ETSR_SLOT_6TH 2'h2
`define ETSR_SLOT_7TH 2'h3
`define ETSR_RST_WORD 32'h00000000
`define ETSR_RST_PHASE 3'h0

`endif

// ### core/etsr_bank_mem.v
`timescale 1ns/100ps
`default_nettype none
module etsr_bank_mem #(
   parameter DW = 63,
   parameter AW = 2
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Write port
   input wire wr_en,
   input wire [AW-1:0] wr_addr,
   input wire [DW-1:0] wr_data,
   // Read port
   input wire rd_en,
   input wire [AW-1:0] rd_addr,
   output reg [DW-1:0] rd_data_q
);

   localparam DEPTH = 1 << AW;

   reg [DW-1:0] mem_q [0:DEPTH-1];
   integer i;

   // ************************************************************
   // Storage, cleared by reset so unwritten slots show zero
   // ************************************************************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {DW{1'b0}};
         end
      end else if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   // Registered read; same-address write shows next read
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= {DW{1'b0}};
      end else if (rd_en) begin
         rd_data_q <= mem_q[rd_addr];
      end
   end

endmodule // etsr_bank_mem
`default_nettype wire

// ### core/etsr_sample_regs.v
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "etsr_defs.vh"
module etsr_sample_regs #(
   parameter UNIT_W = 1
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Avalon-MM slave
   input wire [`ETSR_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Capture results from the timestamp engine
   input wire cap_valid,
   input wire [1:0] cap_slot,
   input wire [UNIT_W-1:0] cap_unit,
   input wire cap_polarity,
   input wire [`ETSR_NANOS_W-1:0] cap_nanos,
   input wire [`ETSR_SECS_W-1:0] cap_secs,
   input wire [2:0] cap_phase_slot
);

   localparam MEM_DW = 1 + `ETSR_NANOS_W + `ETSR_SECS_W;
   localparam MEM_AW = UNIT_W + 1;
   localparam ST_IDLE = 2'h0;
   localparam ST_RWAIT = 2'h1;
   localparam ST_ACK = 2'h2;

   // ************************************************************
   // Helpers
   // ************************************************************
   // Slot index 0..4 to code; 16ns uses 010 since 101 is reserved
   function [`ETSR_PHASE_W-1:0] phase_code;
      input [2:0] slot;
      begin
         case (slot)
            3'h0: phase_code = `ETSR_PH_0NS;
            3'h1: phase_code = `ETSR_PH_8NS;
            3'h2: phase_code = `ETSR_PH_16NS;
            3'h3: phase_code = `ETSR_PH_24NS;
            3'h4: phase_code = `ETSR_PH_32NS;
            default: phase_code = `ETSR_PH_0NS;
         endcase
      end
   endfunction

   function [31:0] phase_word;
      input [`ETSR_PHASE_W-1:0] code;
      begin
         phase_word = {29'h0, code};
      end
   endfunction

   function is_bank_reg;
      input [`ETSR_ADDR_W-1:0] a;
      begin
         is_bank_reg = (a == `ETSR_OFS_S6_NANOS) || (a == `ETSR_OFS_S6_SECS) ||
                       (a == `ETSR_OFS_S7_NANOS) || (a == `ETSR_OFS_S7_SECS);
      end
   endfunction

   // ************************************************************
   // Capture side
   // ************************************************************
   reg [`ETSR_PHASE_W-1:0] s5_phase_q;
   reg [`ETSR_PHASE_W-1:0] s6_phase_q;
   wire cap_bank_wr;
   wire [MEM_AW-1:0] cap_mem_addr;
   wire [MEM_DW-1:0] cap_mem_data;

   assign cap_bank_wr = cap_valid &&
                        ((cap_slot == `ETSR_SLOT_6TH) || (cap_slot == `ETSR_SLOT_7TH));
   // Bank word: unit selects the bank, low bit picks sixth or seventh
   assign cap_mem_addr = {cap_unit, cap_slot == `ETSR_SLOT_7TH};
   assign cap_mem_data = {cap_polarity, cap_nanos, cap_secs};

   // Phase slots are not banked; last capture wins
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s5_phase_q <= `ETSR_RST_PHASE;
         s6_phase_q <= `ETSR_RST_PHASE;
      end else if (cap_valid) begin
         if (cap_slot == `ETSR_SLOT_5TH) begin
            s5_phase_q <= phase_code(cap_phase_slot);
         end
         if (cap_slot == `ETSR_SLOT_6TH) begin
            s6_phase_q <= phase_code(cap_phase_slot);
         end
      end
   end

   // ************************************************************
   // Unit index pointer, the only writable bit
   // ************************************************************
   reg [UNIT_W-1:0] unit_q;
   reg [1:0] state_q;
   wire commit_wr;

   assign commit_wr = (state_q == ST_ACK) && avs_write;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unit_q <= {UNIT_W{1'b0}};
      end else if (commit_wr && (avs_address == `ETSR_OFS_UNIT_INDEX) &&
                   avs_byteenable[1]) begin
         unit_q <= avs_writedata[`ETSR_UNIT_PTR_BIT +: UNIT_W];
      end
   end

   // ************************************************************
   // Bank memory for nanos and seconds
   // ************************************************************
   wire mem_rd_en;
   wire [MEM_AW-1:0] mem_rd_addr;
   wire [MEM_DW-1:0] mem_rd_data;
   wire rd_slot7;

   assign rd_slot7 = (avs_address == `ETSR_OFS_S7_NANOS) ||
                     (avs_address == `ETSR_OFS_S7_SECS);
   assign mem_rd_en = (state_q == ST_IDLE) && avs_read && is_bank_reg(avs_address);
   assign mem_rd_addr = {unit_q, rd_slot7};

   etsr_bank_mem #(
      .DW(MEM_DW),
      .AW(MEM_AW)
   ) u_bank (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(cap_bank_wr),
      .wr_addr(cap_mem_addr),
      .wr_data(cap_mem_data),
      .rd_en(mem_rd_en),
      .rd_addr(mem_rd_addr),
      .rd_data_q(mem_rd_data)
   );

   // ************************************************************
   // Read data selection
   // ************************************************************
   reg [31:0] rd_word;
   wire [31:0] nanos_word;

   // Bit 31 reserved, reads zero
   assign nanos_word = {1'b0, mem_rd_data[MEM_DW-1],
                        mem_rd_data[`ETSR_SECS_W +: `ETSR_NANOS_W]};

   always @* begin
      rd_word = `ETSR_RST_WORD;
      case (avs_address)
         `ETSR_OFS_UNIT_INDEX: rd_word[`ETSR_UNIT_PTR_BIT +: UNIT_W] = unit_q;
         `ETSR_OFS_S5_PHASE: rd_word = phase_word(s5_phase_q);
         `ETSR_OFS_S6_NANOS: rd_word = nanos_word;
         `ETSR_OFS_S6_SECS: rd_word = mem_rd_data[`ETSR_SECS_W-1:0];
         `ETSR_OFS_S6_PHASE: rd_word = phase_word(s6_phase_q);
         `ETSR_OFS_S7_NANOS: rd_word = nanos_word;
         `ETSR_OFS_S7_SECS: rd_word = mem_rd_data[`ETSR_SECS_W-1:0];
         default: rd_word = `ETSR_RST_WORD;
      endcase
   end

   // ************************************************************
   // Bus sequencer
   // ************************************************************
   // Fixed latency: every read waits for the bank memory, even
   // for unbanked registers, which keeps timing uniform for software.
   reg [1:0] state_d;

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (avs_read) begin
               state_d = ST_RWAIT;
            end else if (avs_write) begin
               state_d = ST_ACK;
            end
         end
         ST_RWAIT: state_d = ST_ACK;
         ST_ACK: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= `ETSR_RST_WORD;
      end else begin
         state_q <= state_d;
         case (state_q)
            ST_IDLE: begin
               avs_waitrequest <= !(avs_write && !avs_read);
               avs_readdata <= `ETSR_RST_WORD;
            end
            ST_RWAIT: begin
               avs_waitrequest <= 1'b0;
               avs_readdata <= rd_word;
            end
            ST_ACK: begin
               // Writes to sample registers fall through here unused
               avs_waitrequest <= 1'b1;
               // Read data only stands in the acknowledge cycle
               avs_readdata <= `ETSR_RST_WORD;
            end
            default: begin
               avs_waitrequest <= 1'b1;
               avs_readdata <= `ETSR_RST_WORD;
            end
         endcase
      end
   end

endmodule // etsr_sample_regs
`default_nettype wire

// ### tb/etsr_chk.sv
`timescale 1ns/100ps
`default_nettype none
module etsr_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ****************************************
   // Bus answers
   // ****************************************
   sequence ack_s;
      !avs_waitrequest;
   endsequence
   sequence rd_ack_s;
      ack_s ##0 avs_read;
   endsequence
   wait_pulse_a: assert property (ack_s |=> avs_waitrequest)
      else $error("ack held too long");
   idle_zero_a: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
      else $error("readdata not zero while waiting");
   rd_bound_a: assert property ($rose(avs_read) |-> ##[1:5] ack_s)
      else $error("read not answered");
   wr_bound_a: assert property ($rose(avs_write) |-> ##[1:5] ack_s)
      else $error("write not answered");
   nanos_top_a: assert property (rd_ack_s ##0 (avs_address inside {12'h590, 12'h59C})
      |-> !avs_readdata[31])
      else $error("nanos bit 31 set");
   phase_rsvd_a: assert property (rd_ack_s ##0 (avs_address inside {12'h58C, 12'h598})
      |-> avs_readdata[31:3] == 29'h0 && avs_readdata[2:0] <= 3'h4)
      else $error("bad phase word");
   ptr_only_a: assert property (rd_ack_s ##0 avs_address == 12'h500
      |-> (avs_readdata & ~32'h100) == 32'h0)
      else $error("index has extra bits");
   unmapped_a: assert property (rd_ack_s ##0 !(avs_address inside {12'h500, 12'h58C,
      12'h590, 12'h594, 12'h598, 12'h59C, 12'h5A0}) |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // etsr_chk
bind etsr_sample_regs etsr_chk u_chk (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clk, rst_n, rd, wr, cv, cunit, cpol, wreq;
   logic [11:0] adr;
   logic [31:0] wdat, rdata, csec;
   logic [29:0] cns;
   logic [1:0] cslot;
   logic [2:0] cph;
   logic [3:0] ben;
   int err_count = 0;
   int cmp_count = 0;
   logic [11:0] regs [7] = '{12'h500, 12'h58C, 12'h590, 12'h594, 12'h598, 12'h59C, 12'h5A0};
   // Only byte lane 1 reaches the unit pointer
   etsr_sample_regs #(.UNIT_W(1)) i_dut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(ben),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .cap_valid(cv), .cap_slot(cslot),
      .cap_unit(cunit), .cap_polarity(cpol), .cap_nanos(cns), .cap_secs(csec),
      .cap_phase_slot(cph));
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   // ****************************************
   // Bus and check tasks
   // ****************************************
   task automatic end_sim;
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Held until waitrequest is sampled low; bounded so a dead slave cannot hang us
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      {adr, wdat, rd, wr} <= {a, d, !w, w};
      @(posedge clk);
      while (wreq !== 1'b0) begin
         n++;
         if (n > 20) begin
            err_count++;
            end_sim();
         end
         @(posedge clk);
      end
      q = rdata;
      {rd, wr} <= 2'h0;
      @(posedge clk);
   endtask
   task automatic wb(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), q, e);
   endtask
   task automatic cap(input logic [1:0] s, input logic u, input logic p,
      input logic [29:0] ns, input logic [31:0] sc, input logic [2:0] ph);
      {cv, cslot, cunit, cpol, cns, csec, cph} <= {1'b1, s, u, p, ns, sc, ph};
      @(posedge clk);
      cv <= 1'b0;
      // Let an edge pass so a following capture never re-drives the strobe
      @(posedge clk);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      foreach (regs[i]) rc(regs[i], 32'h0);
      $display("reset values done");
   endtask
   task automatic t_phase;
      logic [2:0] code [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0};
      for (int i = 0; i < 8; i++) begin
         cap(2'h1, 1'b0, 1'b0, 30'h0, 32'h0, 3'(i));
         cap(2'h2, 1'b0, 1'b0, 30'h0, 32'h0, 3'(7 - i));
         rc(12'h58C, {29'h0, code[i]});
         rc(12'h598, {29'h0, code[7 - i]});
      end
      $display("phase codes done");
   endtask
   // Captures into both units, then read through each pointer value
   task automatic t_bank(input logic [1:0] s, input logic [11:0] an);
      cap(s, 1'b0, 1'b1, 30'h3FFFFFFF, 32'hA5A5A5A5, 3'h0);
      cap(s, 1'b1, 1'b0, 30'h15555555, 32'h0000005A, 3'h0);
      wb(12'h500, 32'h0);
      rc(an, 32'h7FFFFFFF);
      rc(an + 12'h4, 32'hA5A5A5A5);
      wb(12'h500, 32'hFFFFFFFF);
      rc(12'h500, 32'h00000100);
      rc(an, 32'h15555555);
      rc(an + 12'h4, 32'h0000005A);
      $display("bank slot %0d done", s);
   endtask
   task automatic t_ro;
      ben <= 4'hD;
      wb(12'h500, 32'h0);
      ben <= 4'hF;
      rc(12'h500, 32'h00000100);
      cap(2'h0, 1'b1, 1'b1, 30'h1, 32'h1, 3'h1);
      rc(12'h58C, 32'h0);
      wb(12'h594, 32'hFFFFFFFF);
      rc(12'h594, 32'h0000005A);
      rc(12'h7FC, 32'h0);
      $display("read-only done");
   endtask
   initial begin
      {rst_n, rd, wr, adr, wdat, cv, cslot, cunit, cpol, cns, csec, cph} = '0;
      ben = 4'hF;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_phase();
      t_bank(2'h2, 12'h590);
      t_bank(2'h3, 12'h59C);
      t_ro();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
